// ### rtl/butterfly_pkg.sv
package butterfly_pkg;

  // default datapath shape
  localparam int unsigned DEF_IN_W = 16;
  localparam int unsigned DEF_STAGES = 3;
  localparam int unsigned DEF_OUT_W = 16;
  localparam int unsigned DEF_OUT_LSB = 4;
  localparam int unsigned MIN_STAGES = 3;

  // register byte addresses
  localparam logic [3:0] REG_CTRL_ADDR = 4'h0;
  localparam logic [3:0] REG_STATUS_ADDR = 4'h4;
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bus-side state carried as one group
  typedef struct packed {
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [31:0] adv_count;
  } bus_state_s;

endpackage

// ### rtl/complex_butterfly_unit.sv
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module complex_butterfly_unit #(
  parameter int unsigned IN_W = butterfly_pkg::DEF_IN_W,
  parameter int unsigned NUM_STAGES = butterfly_pkg::DEF_STAGES,
  parameter bit FULL_RES = 1'b0,
  parameter int unsigned OUT_W = butterfly_pkg::DEF_OUT_W,
  parameter int unsigned OUT_LSB = butterfly_pkg::DEF_OUT_LSB,
  parameter bit fixed_twiddle_option = 1'b0,
  parameter logic signed [IN_W-1:0] W_RE_CONST = '0,
  parameter logic signed [IN_W-1:0] W_IM_CONST = '0,
  parameter bit USE_ENA = 1'b0,
  parameter bit USE_ACLR = 1'b0,
  localparam int unsigned FW = 2 * IN_W + 2,
  localparam int unsigned OW = FULL_RES ? FW : OUT_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // optional controls
  input wire logic ena,
  input wire logic aclr,
  // operands
  input wire logic signed [IN_W-1:0] a_re,
  input wire logic signed [IN_W-1:0] a_im,
  input wire logic signed [IN_W-1:0] b_re,
  input wire logic signed [IN_W-1:0] b_im,
  input wire logic signed [IN_W-1:0] w_re,
  input wire logic signed [IN_W-1:0] w_im,
  // results
  output logic signed [OW-1:0] sum_re,
  output logic signed [OW-1:0] sum_im,
  output logic signed [OW-1:0] dif_re,
  output logic signed [OW-1:0] dif_im,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int unsigned PW = 2 * IN_W;
  localparam int unsigned DLY = NUM_STAGES - 2;

  // configuration limits checked at elaboration
  if (IN_W < 1 || NUM_STAGES < butterfly_pkg::MIN_STAGES || OW < 1 ||
      (!FULL_RES && OUT_LSB + OUT_W > FW))
  begin : g_bad_cfg
    // stop elaboration on a shape the datapath cannot carry
    $error("complex_butterfly_unit: illegal configuration");
  end

  typedef struct packed {
    logic signed [IN_W-1:0] xr;
    logic signed [IN_W-1:0] xi;
    logic signed [IN_W-1:0] yr;
    logic signed [IN_W-1:0] yi;
    logic signed [IN_W-1:0] vr;
    logic signed [IN_W-1:0] vi;
  } ops_s;

  typedef struct packed {
    logic signed [IN_W-1:0] xr;
    logic signed [IN_W-1:0] xi;
    logic signed [PW-1:0] yv;
    logic signed [PW-1:0] yyvv;
    logic signed [PW-1:0] yyv;
    logic signed [PW-1:0] yvv;
  } prod_s;

  typedef struct packed {
    logic signed [OW-1:0] sre;
    logic signed [OW-1:0] sim;
    logic signed [OW-1:0] dre;
    logic signed [OW-1:0] dim;
  } res_s;

  typedef struct packed {
    ops_s s1;
    prod_s s2;
    res_s [DLY-1:0] dly;
    butterfly_pkg::bus_state_s bus;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic clr;
  logic advance;

  // sign-extend an operand to full precision
  function automatic logic signed [FW-1:0] ext_in(input logic signed [IN_W-1:0] v);
    ext_in = FW'(v);
  endfunction

  // sign-extend a product to full precision
  function automatic logic signed [FW-1:0] ext_p(input logic signed [PW-1:0] v);
    ext_p = FW'(v);
  endfunction

  // pick the output field of a full-precision value
  function automatic logic signed [OW-1:0] pick(input logic signed [FW-1:0] v);
    if (FULL_RES)
      pick = OW'(v);
    else
      pick = v[OUT_LSB +: OW];
  endfunction

  // clear only acts when the option is on
  assign clr = USE_ACLR ? aclr : 1'b0;

  // pipeline advances on enable unless software holds it
  assign advance = (USE_ENA ? ena : 1'b1) & ~st_ff.bus.ctrl[butterfly_pkg::CTRL_HOLD_BIT];

  // next-state logic for datapath and register bus
  always_comb
  begin
    logic signed [FW-1:0] full_sre;
    logic signed [FW-1:0] full_sim;
    logic signed [FW-1:0] full_dre;
    logic signed [FW-1:0] full_dim;
    logic [31:0] rd;
    logic rd_ok;
    logic wr_ok;
    full_sre = '0;
    full_sim = '0;
    full_dre = '0;
    full_dim = '0;
    rd = '0;
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    nxt_st = st_ff;

    // datapath stages, held when not advancing
    if (advance)
    begin
      nxt_st.s1.xr = a_re;
      nxt_st.s1.xi = a_im;
      nxt_st.s1.yr = b_re;
      nxt_st.s1.yi = b_im;
      nxt_st.s1.vr = fixed_twiddle_option ? W_RE_CONST : w_re;
      nxt_st.s1.vi = fixed_twiddle_option ? W_IM_CONST : w_im;
      nxt_st.s2.xr = st_ff.s1.xr;
      nxt_st.s2.xi = st_ff.s1.xi;
      nxt_st.s2.yv = st_ff.s1.yr * st_ff.s1.vr;
      nxt_st.s2.yyvv = st_ff.s1.yi * st_ff.s1.vi;
      nxt_st.s2.yyv = st_ff.s1.yi * st_ff.s1.vr;
      nxt_st.s2.yvv = st_ff.s1.yr * st_ff.s1.vi;
      full_sre = ext_in(st_ff.s2.xr) + ext_p(st_ff.s2.yv) - ext_p(st_ff.s2.yyvv);
      full_sim = ext_in(st_ff.s2.xi) + ext_p(st_ff.s2.yyv) + ext_p(st_ff.s2.yvv);
      full_dre = ext_in(st_ff.s2.xr) - ext_p(st_ff.s2.yv) + ext_p(st_ff.s2.yyvv);
      full_dim = ext_in(st_ff.s2.xi) - ext_p(st_ff.s2.yyv) - ext_p(st_ff.s2.yvv);
      nxt_st.dly[0].sre = pick(full_sre);
      nxt_st.dly[0].sim = pick(full_sim);
      nxt_st.dly[0].dre = pick(full_dre);
      nxt_st.dly[0].dim = pick(full_dim);
      for (int i = 1; i < DLY; i++)
      begin
        nxt_st.dly[i] = st_ff.dly[i-1];
      end
      nxt_st.bus.adv_count = st_ff.bus.adv_count + 32'h0000_0001;
    end

    // write address and data are taken in either order
    if (s_axi_awvalid && st_ff.bus.awready)
    begin
      nxt_st.bus.aw_got = 1'b1;
      nxt_st.bus.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.bus.wready)
    begin
      nxt_st.bus.w_got = 1'b1;
      nxt_st.bus.w_data = s_axi_wdata;
      nxt_st.bus.w_strb = s_axi_wstrb;
    end

    // write commits once both halves are held
    if (st_ff.bus.aw_got && st_ff.bus.w_got && !st_ff.bus.bvalid)
    begin
      wr_ok = (st_ff.bus.aw_addr == butterfly_pkg::REG_CTRL_ADDR) ||
              (st_ff.bus.aw_addr == butterfly_pkg::REG_STATUS_ADDR);
      if (st_ff.bus.aw_addr == butterfly_pkg::REG_CTRL_ADDR)
      begin
        for (int k = 0; k < 4; k++)
        begin
          if (st_ff.bus.w_strb[k])
            nxt_st.bus.ctrl[k*8 +: 8] = st_ff.bus.w_data[k*8 +: 8];
        end
      end
      nxt_st.bus.bvalid = 1'b1;
      nxt_st.bus.bresp = wr_ok ? butterfly_pkg::RESP_OKAY : butterfly_pkg::RESP_SLVERR;
      nxt_st.bus.aw_got = 1'b0;
      nxt_st.bus.w_got = 1'b0;
    end
    else if (st_ff.bus.bvalid && s_axi_bready)
      nxt_st.bus.bvalid = 1'b0;

    nxt_st.bus.awready = !nxt_st.bus.aw_got && !nxt_st.bus.bvalid;
    nxt_st.bus.wready = !nxt_st.bus.w_got && !nxt_st.bus.bvalid;

    // read returns one cycle after the address is taken
    if (s_axi_arvalid && st_ff.bus.arready)
    begin
      unique case (s_axi_araddr)
        butterfly_pkg::REG_CTRL_ADDR:
        begin
          rd = st_ff.bus.ctrl;
          rd_ok = 1'b1;
        end
        butterfly_pkg::REG_STATUS_ADDR:
        begin
          rd = st_ff.bus.adv_count;
          rd_ok = 1'b1;
        end
        default:
        begin
          rd = '0;
          rd_ok = 1'b0;
        end
      endcase
      nxt_st.bus.rvalid = 1'b1;
      nxt_st.bus.rdata = rd;
      nxt_st.bus.rresp = rd_ok ? butterfly_pkg::RESP_OKAY : butterfly_pkg::RESP_SLVERR;
    end
    else if (st_ff.bus.rvalid && s_axi_rready)
      nxt_st.bus.rvalid = 1'b0;
    nxt_st.bus.arready = !nxt_st.bus.rvalid;

    // synchronous reset
    if (!aresetn)
    begin
      nxt_st = '0;
      nxt_st.bus.ctrl = butterfly_pkg::CTRL_RESET;
      nxt_st.bus.awready = 1'b1;
      nxt_st.bus.wready = 1'b1;
      nxt_st.bus.arready = 1'b1;
    end
  end

  // state register, cleared at once by the asynchronous clear
  always_ff @(posedge aclk or posedge clr)
  begin
    if (clr)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // outputs straight from flops
  assign sum_re = st_ff.dly[DLY-1].sre;
  assign sum_im = st_ff.dly[DLY-1].sim;
  assign dif_re = st_ff.dly[DLY-1].dre;
  assign dif_im = st_ff.dly[DLY-1].dim;
  assign s_axi_awready = st_ff.bus.awready;
  assign s_axi_wready = st_ff.bus.wready;
  assign s_axi_bvalid = st_ff.bus.bvalid;
  assign s_axi_bresp = st_ff.bus.bresp;
  assign s_axi_arready = st_ff.bus.arready;
  assign s_axi_rvalid = st_ff.bus.rvalid;
  assign s_axi_rdata = st_ff.bus.rdata;
  assign s_axi_rresp = st_ff.bus.rresp;

endmodule // complex_butterfly_unit

`default_nettype wire

// ### rtl/illegal_cfg_placeholder.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### dv/butterfly_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module butterfly_monitor #(
  parameter int unsigned IN_W = 16,
  parameter bit FULL_RES = 1'b0,
  parameter int unsigned OUT_W = 16,
  parameter int unsigned OUT_LSB = 4,
  parameter bit USE_ENA = 1'b0,
  parameter bit USE_ACLR = 1'b0,
  localparam int unsigned FW = 2 * IN_W + 2,
  localparam int unsigned OW = FULL_RES ? FW : OUT_W,
  localparam int unsigned SH = FULL_RES ? 0 : OUT_LSB
) (
  // clock, reset, controls
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ena,
  input wire logic aclr,
  // operands
  input wire logic signed [IN_W-1:0] a_re,
  input wire logic signed [IN_W-1:0] a_im,
  input wire logic signed [IN_W-1:0] b_re,
  input wire logic signed [IN_W-1:0] b_im,
  input wire logic signed [IN_W-1:0] w_re,
  input wire logic signed [IN_W-1:0] w_im,
  // results
  input wire logic signed [OW-1:0] sum_re,
  input wire logic signed [OW-1:0] sum_im,
  input wire logic signed [OW-1:0] dif_re,
  input wire logic signed [OW-1:0] dif_im,
  // bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid
);
  logic signed [FW-1:0] sr, si, dr, di;
  logic [4*OW-1:0] got;
  logic en;
  // full-precision reference taken from the present operands
  assign sr = a_re + b_re * w_re - b_im * w_im;
  assign si = a_im + b_im * w_re + b_re * w_im;
  assign dr = a_re - b_re * w_re + b_im * w_im;
  assign di = a_im - b_im * w_re - b_re * w_im;
  assign got = {sum_re, sum_im, dif_re, dif_im};
  assign en = ena || !USE_ENA;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || aclr);
  a_sum_path: assert property (en [*3] ##1 1'b1 |-> {sum_re, sum_im} == $past({OW'(sr >>> SH), OW'(si >>> SH)}, 3))
    else $error("sum result wrong");
  a_dif_path: assert property (en [*3] ##1 1'b1 |-> {dif_re, dif_im} == $past({OW'(dr >>> SH), OW'(di >>> SH)}, 3))
    else $error("difference result wrong");
  a_hold_when_off: assert property (USE_ENA && !ena |=> $stable(got))
    else $error("outputs moved with enable low");
  a_clear_zero: assert property (disable iff (!aresetn) USE_ACLR && aclr |-> got == '0)
    else $error("outputs not cleared");
  a_reset_zero: assert property (disable iff (1'b0) !aresetn |=> got == '0)
    else $error("outputs not zero after reset");
  a_fill_zero: assert property ($rose(aresetn) |-> (got == '0) [*3])
    else $error("pipeline shorter than three stages");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_write_answer: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid, 2) && $past(s_axi_wvalid, 2))
    else $error("write answer without request");
  // main scenarios seen
  c_ena_low: cover property (!ena);
  c_clear: cover property (aclr);
  c_read: cover property (s_axi_rvalid);
endmodule // butterfly_monitor
bind complex_butterfly_unit butterfly_monitor #(.IN_W(IN_W), .FULL_RES(FULL_RES), .OUT_W(OUT_W),
  .OUT_LSB(OUT_LSB), .USE_ENA(USE_ENA), .USE_ACLR(USE_ACLR)) mon (.*);
`default_nettype wire

// ### dv/operand_source.sv
`timescale 1ns/1ps
`default_nettype none
module operand_source #(
  parameter int unsigned IN_W = 16
) (
  // packed operand word
  input wire logic [6*IN_W-1:0] ops,
  // operand vectors
  output logic signed [IN_W-1:0] a_re,
  output logic signed [IN_W-1:0] a_im,
  output logic signed [IN_W-1:0] b_re,
  output logic signed [IN_W-1:0] b_im,
  output logic signed [IN_W-1:0] w_re,
  output logic signed [IN_W-1:0] w_im
);
  // separate two's complement vectors of exactly the input width
  assign {a_re, a_im, b_re, b_im, w_re, w_im} = ops;
endmodule // operand_source
`default_nettype wire

// ### dv/complex_butterfly_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module complex_butterfly_unit_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ena = 1'b0;
  logic aclr = 1'b0;
  logic [95:0] ops = '0;
  logic signed [15:0] a_re, a_im, b_re, b_im, w_re, w_im;
  logic signed [15:0] sum_re, sum_im, dif_re, dif_im;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [63:0] outs, prev;
  int n_errors = 0, tests_run = 0;
  logic [95:0] rows [4] = '{96'h0001_0002_0003_0004_0005_0006, 96'h8000_8000_8000_8000_8000_8000,
    96'h7fff_8000_7fff_7fff_8000_7fff, 96'hffff_0001_1234_fedc_0100_ff00};
  // partner and design
  operand_source src (.*);
  complex_butterfly_unit #(.USE_ENA(1'b1), .USE_ACLR(1'b1)) dut (.*);
  assign outs = {sum_re, sum_im, dif_re, dif_im};
  // clock of 100 ns
  always #50 aclk = ~aclk;
  // result slice bits 19:4 of the 34-bit values
  function automatic logic [63:0] expect_of(input logic [95:0] v);
    logic signed [15:0] x, xi, y, yi, c, ci;
    logic signed [33:0] sr, si, dr, di;
    {x, xi, y, yi, c, ci} = v;
    sr = x + y * c - yi * ci;
    si = xi + yi * c + y * ci;
    dr = x - y * c + yi * ci;
    di = xi - yi * c - y * ci;
    return {sr[19:4], si[19:4], dr[19:4], di[19:4]};
  endfunction
  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    tests_run++;
    if (got !== want)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
    end
  endtask
  // verdict
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one register transfer, write or read
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_araddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    if (k == 40)
    begin
      n_errors++;
      close_out();
    end
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    ena <= 1'b1;
    #1 chk(outs, '0);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge aclk);
      ops <= rows[i % 4];
      #1;
      if (i >= 3)
        chk(outs, expect_of(rows[i - 3]));
    end
    @(posedge aclk);
    ena <= 1'b0;
    ops <= rows[1];
    #1 prev = outs;
    repeat (4) @(posedge aclk);
    #1 chk(outs, prev);
    @(posedge aclk);
    ena <= 1'b1;
    repeat (3) @(posedge aclk);
    #1 chk(outs, expect_of(rows[1]));
    @(posedge aclk);
    aclr <= 1'b1;
    #1 chk(outs, '0);
    @(posedge aclk);
    aclr <= 1'b0;
    ena <= 1'b0;
    bus(1'b1, butterfly_pkg::REG_CTRL_ADDR, 32'h1);
    bus(1'b0, butterfly_pkg::REG_CTRL_ADDR, '0);
    chk({30'h0, r, q}, {30'h0, butterfly_pkg::RESP_OKAY, 32'h1});
    bus(1'b0, butterfly_pkg::REG_STATUS_ADDR, '0);
    chk({30'h0, r, q}, {30'h0, butterfly_pkg::RESP_OKAY, 32'h0});
    bus(1'b0, 4'h8, '0);
    chk({30'h0, r, q}, {30'h0, butterfly_pkg::RESP_SLVERR, 32'h0});
    bus(1'b1, 4'h8, 32'h1);
    chk({62'h0, r}, {62'h0, butterfly_pkg::RESP_SLVERR});
    bus(1'b1, butterfly_pkg::REG_CTRL_ADDR, 32'h0);
    chk({62'h0, r}, {62'h0, butterfly_pkg::RESP_OKAY});
    close_out();
  end
endmodule // complex_butterfly_unit_test
`default_nettype wire
